/* src/guard_pkg.sv */
// Purpose : Shared constants for the windowed watchdog timer
// Assumes : 8-bit register port, one clock (ref_clk, 125 MHz)
// Notes   : Offsets, field positions, reset values and counts live here only
//
// Notes on behaviour
// - 16-bit up count at pclk/2 or pclk/128
// - Two cascaded 8-bit stages, low carries high
// - Disabled after reset; nothing counts or fires
// - Enable loads reload:00 and starts counting
// - Service clears low byte, loads high byte
// - Hardware clears refresh request after service
// - Overflow without service: NMI, enter prewarning
// - Prewarning lasts 0x30 ticks, then system reset
// - Prewarning ignores refresh and disable
// - Refresh at overflow wins; no prewarning
// - Windowed refresh below window:00 forces reset
// - Period = 2^(1+6*sel)*(65536-reload*256)/fpclk
// - Window leaves period unchanged, same formula
// - Debug halt with suspend bit stops count
// - Count is read-only; writes ignored
// - Writing 1 to refresh bit starts service
// - Prewarn flag set on entry, zero after reset

package guard_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W              = 4;
  localparam int          DATA_W              = 8;
  localparam logic [3:0]  OFS_CONTROL         = 4'h0;  // guard_control_reg
  localparam logic [3:0]  OFS_RELOAD          = 4'h1;  // reload_high_byte
  localparam logic [3:0]  OFS_WINDOW          = 4'h2;  // window_bound_byte
  localparam logic [3:0]  OFS_COUNT_LO        = 4'h3;  // guard_count_value low
  localparam logic [3:0]  OFS_COUNT_HI        = 4'h4;  // guard_count_value high
  localparam logic [3:0]  OFS_SUSPEND         = 4'h5;  // suspend_control_reg

  // ----------------------------------------------------------------
  // Control and suspend register fields
  // ----------------------------------------------------------------
  localparam int          BIT_PRESCALE_SEL    = 0;
  localparam int          BIT_REFRESH         = 1;
  localparam int          BIT_ENABLE          = 2;
  localparam int          BIT_PREWARN         = 4;
  localparam int          BIT_WINDOW_EN       = 5;
  localparam int          BIT_SUSPEND         = 0;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE            = 8'h00;
  localparam logic        RST_SUSPEND         = 1'b1;
  localparam logic [7:0]  PREWARN_COUNTS      = 8'h30;
  localparam logic [7:0]  BYTE_MAX            = 8'hff;
  localparam logic [15:0] COUNT_MAX           = 16'hffff;
  localparam int          DIV_FAST            = 2;
  localparam int          DIV_SLOW            = 128;

  // ----------------------------------------------------------------
  // Watchdog phases, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_OFF     = 4'b0001,
    ST_RUN     = 4'b0010,
    ST_PREWARN = 4'b0100,
    ST_RESET   = 4'b1000
  } guard_state_e;

endpackage : guard_pkg

/* src/tick_if.sv */
// Purpose : Carries the count-rate request and tick between watchdog parts
// Assumes : Same clock on both sides
// Notes   : tick is a one-cycle enable pulse
`timescale 1ns/100ps

interface tick_if;
  logic run;       // Prescaler counts while high
  logic slow_sel;  // 0: divide by 2, 1: divide by 128
  logic tick;      // One-cycle count-rate pulse

  modport owner   (output run, output slow_sel, input tick);
  modport divider (input run, input slow_sel, output tick);
endinterface : tick_if

/* src/rate_divider.sv */
// Purpose : Divides ref_clk into the watchdog count-rate enable
// Assumes : Synchronous active-low reset
// Notes   : Restarts from zero whenever run drops, so a fresh start is clean
`timescale 1ns/100ps

module rate_divider #(
  parameter int FAST_DIV = guard_pkg::DIV_FAST,
  parameter int SLOW_DIV = guard_pkg::DIV_SLOW
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic nrst,
  // Tick carrier
  tick_if.divider   tk
);
  localparam int CW = $clog2(SLOW_DIV);

  logic [CW-1:0] div_cnt;  // Cycles since last tick
  logic [CW-1:0] last;     // Terminal count for chosen rate

  // Terminal count follows the selected divider
  assign last = tk.slow_sel ? CW'(SLOW_DIV - 1) : CW'(FAST_DIV - 1);

  // ----------------------------------------------------------------
  // Divider counter and tick pulse
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst || !tk.run) begin
      div_cnt <= '0;
      tk.tick <= 1'b0;
    end else if (div_cnt >= last) begin  // Also catches a rate change mid-count
      div_cnt <= '0;
      tk.tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + CW'(1);
      tk.tick <= 1'b0;
    end
  end
endmodule : rate_divider

/* src/windowed_watchdog_timer.sv */
// Purpose : Windowed 16-bit watchdog with prewarning and debug suspend
// Assumes : ref_clk is the peripheral clock; registers on a plain strobe port
// Notes   : guard_system_reset stays high until nrst; the chip reset loops back
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/100ps

module windowed_watchdog_timer
  import guard_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  // Register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  // Debugger halt, asynchronous pin
  input  wire logic              debug_halted,
  // Watchdog outcomes
  output logic                   timeout_nmi,
  output logic                   guard_system_reset,
  output logic                   prewarn_flag
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  guard_state_e state;                // Watchdog phase
  logic [7:0]   count_lo;             // Low stage of the count
  logic [7:0]   count_hi;             // High stage of the count
  logic [15:0]  count;                // Both stages together
  logic [7:0]   reload_high_byte;     // Service reload for high stage
  logic [7:0]   window_bound_byte;    // Window boundary high byte
  logic         prescale_select;      // 0: /2, 1: /128
  logic         guard_enable;         // Software enable
  logic         window_check_enable;  // Window check on
  logic         refresh_request;      // Pending service, lives one cycle
  logic         debug_halt_suspend;   // Suspend during debug halt
  logic         halt_meta;            // Synchroniser first stage
  logic         halt_sync;            // Synchronised halt
  logic         suspended;            // Count frozen
  logic         advance;              // Count step this cycle
  logic         service;              // Service acts this cycle
  logic         in_window;            // Count below window boundary
  logic         early_refresh;        // Service inside the window
  logic         overflow;             // Count wraps this cycle
  logic         ctrl_wr;              // Control register written
  logic [7:0]   pw_cnt;               // Prewarning ticks elapsed
  logic         pw_done;              // Last prewarning tick
  logic         enter_pw;             // Overflow takes the block into prewarning

  tick_if tk ();

  // ----------------------------------------------------------------
  // Count-rate divider
  // ----------------------------------------------------------------
  // Prescaler input is gated while suspended, as the count clock would be
  assign tk.run      = (state == ST_RUN || state == ST_PREWARN) && !suspended;
  assign tk.slow_sel = prescale_select;

  rate_divider u_rate (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .tk      (tk)
  );

  // ----------------------------------------------------------------
  // Debug halt synchroniser
  // ----------------------------------------------------------------
  // Halt comes from the debug domain; two flops before any use
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      halt_meta <= 1'b0;
      halt_sync <= 1'b0;
    end else begin
      halt_meta <= debug_halted;
      halt_sync <= halt_meta;
    end
  end

  // ----------------------------------------------------------------
  // Combinational decode
  // ----------------------------------------------------------------
  assign count         = {count_hi, count_lo};
  assign suspended     = halt_sync && debug_halt_suspend;
  assign advance       = tk.tick && !suspended;
  assign ctrl_wr       = wr && (addr == OFS_CONTROL);
  // Service only acts in normal counting
  assign service       = refresh_request && (state == ST_RUN);
  assign in_window     = count < {window_bound_byte, RST_BYTE};
  assign early_refresh = service && window_check_enable && in_window;
  assign overflow      = advance && (count == COUNT_MAX);
  assign pw_done       = advance && (pw_cnt == PREWARN_COUNTS - 8'h01);
  // A disable written on the overflow edge wins, so a stopped block raises no NMI
  assign enter_pw      = (state == ST_RUN) && overflow && !service && !(ctrl_wr && !wdata[BIT_ENABLE]);

  // ----------------------------------------------------------------
  // Phase machine
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state <= ST_OFF;
    end else begin
      case (state)
        ST_OFF: begin
          if (ctrl_wr && wdata[BIT_ENABLE]) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (early_refresh) begin
            state <= ST_RESET;
          end else if (ctrl_wr && !wdata[BIT_ENABLE]) begin
            state <= ST_OFF;
          end else if (overflow && !service) begin
            state <= ST_PREWARN;
          end
        end
        ST_PREWARN: begin
          // Disable writes have no hold here
          if (pw_done) begin
            state <= ST_RESET;
          end
        end
        ST_RESET: begin
          state <= ST_RESET;  // Only nrst leaves this phase
        end
        default: begin
          state <= ST_OFF;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Two-stage counter
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      count_lo <= RST_BYTE;
      count_hi <= RST_BYTE;
    end else if (state == ST_OFF && ctrl_wr && wdata[BIT_ENABLE]) begin
      count_lo <= RST_BYTE;
      count_hi <= reload_high_byte;
    end else if (service) begin
      // Service wins over a coinciding overflow step
      count_lo <= RST_BYTE;
      count_hi <= reload_high_byte;
    end else if (state == ST_RUN && advance) begin
      count_lo <= count_lo + 8'h01;
      if (count_lo == BYTE_MAX) begin
        count_hi <= count_hi + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Prewarning tick count
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst || state != ST_PREWARN) begin
      pw_cnt <= RST_BYTE;
    end else if (advance) begin
      pw_cnt <= pw_cnt + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      prescale_select     <= 1'b0;
      guard_enable        <= 1'b0;
      window_check_enable <= 1'b0;
    end else if (ctrl_wr) begin
      prescale_select     <= wdata[BIT_PRESCALE_SEL];
      window_check_enable <= wdata[BIT_WINDOW_EN];
      // Clearing enable is refused during prewarning and after reset fires
      if (state == ST_OFF || state == ST_RUN) begin
        guard_enable <= wdata[BIT_ENABLE];
      end
    end
  end

  // ----------------------------------------------------------------
  // Refresh request, one-cycle life
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      refresh_request <= 1'b0;
    end else if (ctrl_wr && wdata[BIT_REFRESH]) begin
      refresh_request <= 1'b1;
    end else begin
      refresh_request <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Reload, window and suspend registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      reload_high_byte   <= RST_BYTE;
      window_bound_byte  <= RST_BYTE;
      debug_halt_suspend <= RST_SUSPEND;
    end else if (wr) begin
      case (addr)
        OFS_RELOAD:  reload_high_byte   <= wdata;
        OFS_WINDOW:  window_bound_byte  <= wdata;
        OFS_SUSPEND: debug_halt_suspend <= wdata[BIT_SUSPEND];
        default: begin
          // Count addresses and unmapped ones ignore writes
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outcome outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      timeout_nmi        <= 1'b0;
      prewarn_flag       <= 1'b0;
      guard_system_reset <= 1'b0;
    end else begin
      // NMI request is a one-cycle pulse on prewarning entry
      timeout_nmi <= enter_pw;
      if (enter_pw) begin
        prewarn_flag <= 1'b1;
      end
      if ((state == ST_PREWARN && pw_done) || (state == ST_RUN && early_refresh)) begin
        guard_system_reset <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rdata <= RST_BYTE;
    end else if (rd) begin
      case (addr)
        OFS_CONTROL: begin
          rdata                   <= RST_BYTE;
          rdata[BIT_PRESCALE_SEL] <= prescale_select;
          rdata[BIT_REFRESH]      <= refresh_request;
          rdata[BIT_ENABLE]       <= guard_enable;
          rdata[BIT_PREWARN]      <= prewarn_flag;
          rdata[BIT_WINDOW_EN]    <= window_check_enable;
        end
        OFS_RELOAD:   rdata <= reload_high_byte;
        OFS_WINDOW:   rdata <= window_bound_byte;
        OFS_COUNT_LO: rdata <= count_lo;
        OFS_COUNT_HI: rdata <= count_hi;
        OFS_SUSPEND: begin
          rdata              <= RST_BYTE;
          rdata[BIT_SUSPEND] <= debug_halt_suspend;
        end
        default:      rdata <= RST_BYTE;  // Unmapped reads zero
      endcase
    end else begin
      rdata <= RST_BYTE;  // Data stands one cycle only
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_off_no_count: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (state == ST_OFF && !ctrl_wr) |=> $stable(count) && !guard_system_reset)
    else $error("count moved while disabled");

  a_enable_loads: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (state == ST_OFF && ctrl_wr && wdata[BIT_ENABLE])
      |=> state == ST_RUN && count == {$past(reload_high_byte), RST_BYTE})
    else $error("enable did not load start value");

  a_service_reload: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (service && !early_refresh) |=> count == {$past(reload_high_byte), RST_BYTE} && state == ST_RUN)
    else $error("service did not reload");

  a_refresh_clears: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (refresh_request && !(ctrl_wr && wdata[BIT_REFRESH])) |=> !refresh_request)
    else $error("refresh request not cleared");

  a_count_steps: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (state == ST_RUN && advance && !refresh_request && !ctrl_wr && count != COUNT_MAX)
      |=> count == $past(count) + 16'h0001)
    else $error("counter step wrong");

  a_overflow_nmi: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (state == ST_RUN && overflow && !refresh_request && !ctrl_wr)
      |=> timeout_nmi && prewarn_flag && state == ST_PREWARN ##1 !timeout_nmi)
    else $error("overflow did not raise prewarning");

  a_race_refresh: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (state == ST_RUN && overflow && service && !early_refresh) |=> state == ST_RUN && !prewarn_flag)
    else $error("refresh lost to overflow");

  a_prewarn_end: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (state == ST_PREWARN && advance && pw_cnt == PREWARN_COUNTS - 8'h01)
      |=> guard_system_reset ##1 guard_system_reset)
    else $error("prewarning end missed reset");

  a_prewarn_locked: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (state == ST_PREWARN) |=> (state == ST_PREWARN || state == ST_RESET) && guard_enable)
    else $error("prewarning left or disabled");

  a_window_reset: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (state == ST_RUN && refresh_request && window_check_enable && in_window) |=> guard_system_reset)
    else $error("early refresh did not reset");

  a_suspend_hold: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (state == ST_RUN && suspended && !refresh_request && !ctrl_wr) |=> $stable(count))
    else $error("count moved during suspend");

  a_flag_sticky: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    prewarn_flag |=> prewarn_flag)
    else $error("prewarn flag dropped");

  a_prewarn_refresh: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (state == ST_PREWARN && refresh_request) |=> $stable(count) && state != ST_RUN)
    else $error("refresh acted in prewarning");

  a_tick_only: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (state == ST_RUN && !advance && !refresh_request && !ctrl_wr) |=> $stable(count))
    else $error("count moved without tick");

endmodule : windowed_watchdog_timer

/* tb/reset_loop_model.sv */
// Purpose : Far-side model of the chip reset logic and the CPU's NMI intake
// Assumes : One clock; guard_system_reset is a level that holds until chip reset
// Notes   : One register stage gives a reset pulse two edges long
`timescale 1ns/100ps

module reset_loop_model (
  // Clock
  input  wire logic ref_clk,
  // Watchdog outcomes
  input  wire logic timeout_nmi,
  input  wire logic guard_system_reset,
  // Reset back to the block, NMI tally to the bench
  output logic      chip_rst_req,
  output int        nmi_count
);
  // ----------------------------------------------------------------
  // Reset loop and NMI intake
  // ----------------------------------------------------------------
  initial begin
    chip_rst_req = 1'b0;
    nmi_count    = 0;
  end
  // The reset request follows the watchdog level one edge late, like a real reset tree
  always @(posedge ref_clk) begin
    chip_rst_req <= guard_system_reset;
    if (timeout_nmi === 1'b1) begin
      nmi_count <= nmi_count + 1;
    end
  end
endmodule : reset_loop_model

/* tb/windowed_watchdog_timer_bench.sv */
// Purpose : Self-checking bench for the windowed watchdog timer
// Assumes : One-cycle register strobes; chip reset looped back by the far-side model
// Notes   : Period checks allow a few cycles for divider phase and output registers
`timescale 1ns/100ps

module windowed_watchdog_timer_bench;
  import guard_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic              ref_clk, nrst_b, nrst, wr, rd, debug_halted;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, rv, rv2, rel;
  logic              timeout_nmi, guard_system_reset, prewarn_flag, chip_rst_req;
  int                nmi_count, fail_count, check_count, cyc, nmi0;
  time               t0, t_nmi;
  integer            seed = 32'hd266cf81;
  // Expected reset values, addresses 0 to 6 (6 is unmapped)
  logic [7:0]        rst_vals[$] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};

  // Clock, 8 ns
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Chip reset is the bench reset merged with the watchdog's own loop
  assign nrst = nrst_b & ~chip_rst_req;

  windowed_watchdog_timer dut (.ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .debug_halted(debug_halted), .timeout_nmi(timeout_nmi),
    .guard_system_reset(guard_system_reset), .prewarn_flag(prewarn_flag));
  reset_loop_model far_end (.ref_clk(ref_clk), .timeout_nmi(timeout_nmi),
    .guard_system_reset(guard_system_reset), .chip_rst_req(chip_rst_req), .nmi_count(nmi_count));

  // ----------------------------------------------------------------
  // Checks and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Cycle counts may differ by the divider's phase, hence a tolerance
  task automatic chk_near(input int got, input int exp, input int tol);
    check_count++;
    if (got < exp - tol || got > exp + tol) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_near
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
    t0 = $time;
  endtask : wreg
  // Read data stand only in the cycle after the strobe
  task automatic rreg(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    @(negedge ref_clk);
    d = rdata;
  endtask : rreg
  // Bounded wait for the NMI pulse or the reset level; cyc counts from t0
  task automatic wait_for(input bit want_rst, input int bound);
    int k;
    k = 0;
    while (((want_rst ? guard_system_reset : timeout_nmi) !== 1'b1) && k < bound) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    cyc = int'(($time - t0) / 8);
    t0  = $time;
    if (k >= bound) begin
      fail_count++;
      $display("[ERR] t=%0t waited=%h bound=%h", $time, k, bound);
      finish_test();
    end
  endtask : wait_for
  function automatic int period(input int sel, input int r);
    return (1 << (1 + sel * 6)) * (65536 - r * 256);
  endfunction : period
  task automatic reset_vals();
    for (int i = 0; i < rst_vals.size(); i++) begin
      rreg(i[3:0], rv);
      chk(rv, rst_vals[i]);
    end
  endtask : reset_vals
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    nrst_b = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    debug_halted = 1'b0;
    fail_count = 0;
    check_count = 0;
    repeat (6) @(posedge ref_clk);
    nrst_b <= 1'b1;
    reset_vals();
    // Count ignores writes; a disabled block never fires even with a short reload
    wreg(OFS_COUNT_LO, 8'h55);
    wreg(OFS_COUNT_HI, 8'haa);
    wreg(OFS_RELOAD, 8'hff);
    repeat (1000) @(posedge ref_clk);
    rreg(OFS_COUNT_HI, rv);
    chk(rv, 8'h00);
    chk(nmi_count, 0);
    // Debug halt freezes the count while the suspend bit is set
    wreg(OFS_RELOAD, 8'h00);
    wreg(OFS_CONTROL, 8'h04);
    debug_halted <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rreg(OFS_COUNT_LO, rv);
    repeat (64) @(posedge ref_clk);
    rreg(OFS_COUNT_LO, rv2);
    chk(rv2, rv);
    wreg(OFS_SUSPEND, 8'h00);
    repeat (20) @(posedge ref_clk);
    rreg(OFS_COUNT_LO, rv2);
    chk(rv2 !== rv, 1);
    wreg(OFS_CONTROL, 8'h00);
    wreg(OFS_SUSPEND, 8'h01);
    debug_halted <= 1'b0;
    // Random reload, fast rate: start value, period, prewarning and its refusals
    rel = 8'($random(seed));
    rel = {3'b111, rel[4:0]};
    wreg(OFS_RELOAD, rel);
    wreg(OFS_CONTROL, 8'h04);
    rreg(OFS_COUNT_HI, rv);
    chk(rv, rel);
    wait_for(1'b0, 20000);
    chk_near(cyc, period(0, rel), 4);
    t_nmi = t0;
    @(negedge ref_clk);
    chk(prewarn_flag, 1'b1);
    wreg(OFS_CONTROL, 8'h02);
    wreg(OFS_CONTROL, 8'h00);
    rreg(OFS_CONTROL, rv);
    chk(rv, 8'h14);
    // Prewarning is timed from the NMI edge, not from the refused writes
    t0 = t_nmi;
    wait_for(1'b1, 300);
    chk_near(cyc, int'(PREWARN_COUNTS) * DIV_FAST, 1);
    chk(nmi_count, 1);
    repeat (5) @(posedge ref_clk);
    reset_vals();
    // Legal late service with the window on: reload, auto-clear, unchanged period
    wreg(OFS_RELOAD, 8'hfe);
    wreg(OFS_WINDOW, 8'hfe);
    wreg(OFS_CONTROL, 8'h24);
    repeat (100) @(posedge ref_clk);
    wreg(OFS_CONTROL, 8'h24);
    wreg(OFS_CONTROL, 8'h26);
    rreg(OFS_COUNT_HI, rv);
    chk(rv, 8'hfe);
    rreg(OFS_CONTROL, rv);
    chk(rv, 8'h24);
    rreg(OFS_COUNT_LO, rv);
    chk(rv < 8'h08, 1);
    chk(guard_system_reset, 1'b0);
    wait_for(1'b0, 2000);
    chk_near(cyc, period(0, 8'hfe), 10);
    wait_for(1'b1, 300);
    repeat (5) @(posedge ref_clk);
    // Early service inside the window: reset at once, no NMI
    nmi0 = nmi_count;
    wreg(OFS_RELOAD, 8'h10);
    wreg(OFS_WINDOW, 8'h80);
    wreg(OFS_CONTROL, 8'h24);
    wreg(OFS_CONTROL, 8'h26);
    wait_for(1'b1, 8);
    chk_near(cyc, 1, 1);
    chk(nmi_count, nmi0);
    chk(prewarn_flag, 1'b0);
    repeat (5) @(posedge ref_clk);
    // Refresh request standing on the overflow edge: 256 ticks land 513 cycles after enable
    nmi0 = nmi_count;
    wreg(OFS_RELOAD, BYTE_MAX);
    wreg(OFS_CONTROL, 8'h04);
    repeat (510) @(posedge ref_clk);
    wreg(OFS_CONTROL, 8'h06);
    repeat (4) @(negedge ref_clk);
    chk(prewarn_flag, 1'b0);
    chk(nmi_count, nmi0);
    rreg(OFS_COUNT_LO, rv);
    chk(rv < 8'h08, 1);
    wreg(OFS_CONTROL, 8'h00);
    // Slow rate: period and prewarning both scale by 128
    wreg(OFS_RELOAD, 8'hff);
    wreg(OFS_CONTROL, 8'h05);
    wait_for(1'b0, 34000);
    chk_near(cyc, period(1, 8'hff), 130);
    wait_for(1'b1, 7000);
    chk_near(cyc, 8'h30 * 128, 130);
    finish_test();
  end
endmodule : windowed_watchdog_timer_bench
